// [core/tle_pkg.sv]
// Package for the transactional lock elision block.
// Assumes a single core clock domain; no software-visible registers.
package tle_pkg;
  localparam int ADDR_W = 32;
  localparam int LINE_LSB = 6;
  localparam int LINE_W = ADDR_W - LINE_LSB;
  localparam int SET_DEPTH = 8;
  localparam int SET_IDX_W = 3;
  localparam int NEST_W = 3;
  localparam logic [NEST_W-1:0] MAX_NEST = 3'h7;
  localparam int DATA_W = 32;
  localparam int ACC_W = 32;
  localparam int ST_EXPLICIT = 0;
  localparam int ST_RETRY = 1;
  localparam int ST_CONFLICT = 2;
  localparam int ST_OVERFLOW = 3;
  localparam int ST_NEST = 5;
  localparam int ST_CODE_LSB = 24;
  localparam logic [7:0] PREFIX_ACQ = 8'hf2;
  localparam logic [7:0] PREFIX_REL = 8'hf3;
  typedef enum logic [1:0] {
    TLE_IDLE = 2'b00,
    TLE_PREFIX = 2'b01,
    TLE_EXPLICIT = 2'b10,
    TLE_FALLBACK = 2'b11
  } tle_state_e;
endpackage : tle_pkg

// [core/tle_core.sv]
// Transactional execution tracker: read/write sets, conflicts, commit, abort.
// Assumes the pipeline presents one op per cycle and holds the checkpoint.
`timescale 1ns/100ps

// Notes on behaviour
// - Read and write sets kept per line
// - Peer read of write-set or write conflicts
// - Transactional stores hidden until commit, then drained one entry per cycle
// - Abort drops buffered stores, restores state
// - Abort when set capacity is exceeded
// - External abort causes are accepted
// - Acquire-elide: no write, lock in read-set
// - Lock stays free to peers
// - Local lock read returns elided value
// - Release-elide of old value suppresses write, commits
// - Failed elided region reruns without elision
// - Legacy repeat prefixes ignored without elision feature
// - Begin offset becomes fallback address
// - Explicit abort resumes at fallback with status
// - Force-abort immediate goes to accumulator
// - Query reports transactional state
// - Accumulator status bits encode abort cause
// - Nesting count; commit at zero; overflow aborts
// - Nested abort restores to outermost start
module tle_core (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic elision_enable,
  input wire logic op_valid,
  input wire logic [7:0] op_prefix,
  input wire logic op_is_lock_acq,
  input wire logic op_is_lock_rel,
  input wire logic op_is_load,
  input wire logic op_is_store,
  input wire logic op_begin,
  input wire logic op_end,
  input wire logic op_force_abort,
  input wire logic op_query,
  input wire logic [7:0] op_imm,
  input wire logic [31:0] op_offset,
  input wire logic [31:0] op_pc,
  input wire logic [tle_pkg::ADDR_W-1:0] op_addr,
  input wire logic [tle_pkg::DATA_W-1:0] op_wdata,
  input wire logic [tle_pkg::DATA_W-1:0] op_lock_old,
  input wire logic sys_abort,
  input wire logic peer_valid,
  input wire logic peer_write,
  input wire logic [tle_pkg::ADDR_W-1:0] peer_addr,
  output logic tx_active,
  output logic query_result,
  output logic mem_write_req,
  output logic [tle_pkg::ADDR_W-1:0] mem_write_addr,
  output logic [tle_pkg::DATA_W-1:0] mem_write_data,
  output logic lock_fwd_hit,
  output logic [tle_pkg::DATA_W-1:0] lock_fwd_data,
  output logic commit_pulse,
  output logic abort_pulse,
  output logic restore_state,
  output logic redirect_valid,
  output logic [31:0] redirect_pc,
  output logic acc_write,
  output logic [tle_pkg::ACC_W-1:0] acc_value,
  output logic rerun_no_elide
);
  tle_pkg::tle_state_e state;
  logic [tle_pkg::LINE_W-1:0] rd_line [tle_pkg::SET_DEPTH];
  logic [tle_pkg::SET_DEPTH-1:0] rd_vld;
  logic [tle_pkg::LINE_W-1:0] wr_line [tle_pkg::SET_DEPTH];
  logic [tle_pkg::SET_DEPTH-1:0] wr_vld;
  logic [tle_pkg::DATA_W-1:0] wr_data [tle_pkg::SET_DEPTH];
  logic [tle_pkg::ADDR_W-1:0] wr_addr [tle_pkg::SET_DEPTH];
  logic [tle_pkg::NEST_W:0] nest;
  logic [31:0] fallback_pc;
  logic [tle_pkg::ADDR_W-1:0] lock_addr;
  logic [tle_pkg::DATA_W-1:0] lock_val;
  logic [tle_pkg::DATA_W-1:0] lock_old;
  logic lock_held;
  logic no_elide;
  logic [tle_pkg::SET_IDX_W:0] drain_idx;
  logic draining;
  logic [tle_pkg::SET_DEPTH-1:0] drain_vld;

  function automatic logic [tle_pkg::LINE_W-1:0] line_of(input logic [tle_pkg::ADDR_W-1:0] a);
    line_of = a[tle_pkg::ADDR_W-1:tle_pkg::LINE_LSB];
  endfunction : line_of

  function automatic int first_free(input logic [tle_pkg::SET_DEPTH-1:0] v);
    first_free = tle_pkg::SET_DEPTH;
    for (int i = tle_pkg::SET_DEPTH - 1; i >= 0; i--) begin
      if (!v[i]) begin
        first_free = i;
      end
    end
  endfunction : first_free

  logic in_tx;
  assign in_tx = (state == tle_pkg::TLE_PREFIX) || (state == tle_pkg::TLE_EXPLICIT);
  // Per-line hit vectors
  logic [tle_pkg::SET_DEPTH-1:0] peer_rd_hit, peer_wr_hit, op_rd_hit, op_wr_hit;
  genvar g;
  generate
    for (g = 0; g < tle_pkg::SET_DEPTH; g++) begin : g_hit
      assign peer_rd_hit[g] = rd_vld[g] && rd_line[g] == line_of(peer_addr);
      assign peer_wr_hit[g] = wr_vld[g] && wr_line[g] == line_of(peer_addr);
      assign op_rd_hit[g] = rd_vld[g] && rd_line[g] == line_of(op_addr);
      assign op_wr_hit[g] = wr_vld[g] && wr_line[g] == line_of(op_addr);
    end
  endgenerate

  // Prefix decode; ignored without the feature
  logic acq_el, rel_el, is_load_op, is_store_op;
  assign acq_el = op_valid && op_is_lock_acq && elision_enable && !no_elide
    && op_prefix == tle_pkg::PREFIX_ACQ;
  assign rel_el = op_valid && op_is_lock_rel && elision_enable && state == tle_pkg::TLE_PREFIX
    && op_prefix == tle_pkg::PREFIX_REL;
  assign is_load_op = op_valid && (op_is_load || op_is_lock_acq);
  assign is_store_op = op_valid && (op_is_store || (op_is_lock_acq && !acq_el)
    || (op_is_lock_rel && !rel_el));

  logic conflict;
  assign conflict = in_tx && peer_valid
    && ((|peer_wr_hit) || (peer_write && (|peer_rd_hit)));
  logic lock_line_op;
  assign lock_line_op = lock_held && line_of(op_addr) == line_of(lock_addr);
  logic rd_need, wr_need, rd_over, wr_over;
  assign rd_need = (in_tx || acq_el) && is_load_op && !(|op_rd_hit);
  assign wr_need = in_tx && is_store_op && !(|op_wr_hit) && !lock_line_op;
  assign rd_over = rd_need && first_free(rd_vld) == tle_pkg::SET_DEPTH;
  assign wr_over = wr_need && first_free(wr_vld) == tle_pkg::SET_DEPTH;
  logic rel_match, bad_lock_write;
  assign rel_match = rel_el && op_addr == lock_addr && op_wdata == lock_old;
  assign bad_lock_write = state == tle_pkg::TLE_PREFIX && is_store_op && lock_line_op;
  logic nest_over;
  assign nest_over = in_tx && ((op_valid && op_begin) || acq_el)
    && nest[tle_pkg::NEST_W-1:0] == tle_pkg::MAX_NEST;
  logic force_ab;
  assign force_ab = state == tle_pkg::TLE_EXPLICIT && op_valid && op_force_abort;
  logic do_abort;
  assign do_abort = in_tx && (conflict || rd_over || wr_over || sys_abort || force_ab
    || nest_over || bad_lock_write || (rel_el && !rel_match));
  logic dec_zero;
  assign dec_zero = nest == {{tle_pkg::NEST_W{1'b0}}, 1'b1};
  logic do_commit;
  assign do_commit = !do_abort
    && ((state == tle_pkg::TLE_EXPLICIT && op_valid && op_end && dec_zero)
    || (state == tle_pkg::TLE_PREFIX && rel_match && dec_zero));
  // State and nesting
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= tle_pkg::TLE_IDLE;
      nest <= '0;
    end else if (do_abort) begin
      state <= (state == tle_pkg::TLE_PREFIX) ? tle_pkg::TLE_FALLBACK : tle_pkg::TLE_IDLE;
      nest <= '0;
    end else if (do_commit) begin
      state <= tle_pkg::TLE_IDLE;
      nest <= '0;
    end else begin
      unique case (state)
        tle_pkg::TLE_IDLE: begin
          if (op_valid && op_begin) begin
            state <= tle_pkg::TLE_EXPLICIT;
            nest <= {{tle_pkg::NEST_W{1'b0}}, 1'b1};
          end else if (acq_el) begin
            state <= tle_pkg::TLE_PREFIX;
            nest <= {{tle_pkg::NEST_W{1'b0}}, 1'b1};
          end
        end
        tle_pkg::TLE_PREFIX: begin
          if (acq_el) begin
            nest <= nest + 1'b1;
          end else if (rel_match) begin
            nest <= nest - 1'b1;
          end
        end
        tle_pkg::TLE_EXPLICIT: begin
          if (op_valid && op_begin) begin
            nest <= nest + 1'b1;
          end else if (op_valid && op_end) begin
            nest <= nest - 1'b1;
          end
        end
        tle_pkg::TLE_FALLBACK: begin
          if (op_valid && op_is_lock_rel) begin
            state <= tle_pkg::TLE_IDLE;
          end
        end
      endcase
    end
  end

  // Elision disabled during the non-elided rerun
  always_ff @(posedge core_clk) begin
    if (reset) begin
      no_elide <= 1'b0;
    end else if (do_abort && state == tle_pkg::TLE_PREFIX) begin
      no_elide <= 1'b1;
    end else if (state == tle_pkg::TLE_FALLBACK && op_valid && op_is_lock_rel) begin
      no_elide <= 1'b0;
    end
  end

  // Elided lock tracking
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lock_held <= 1'b0;
      lock_addr <= '0;
      lock_val <= '0;
      lock_old <= '0;
    end else if (do_abort || do_commit) begin
      lock_held <= 1'b0;
    end else if (acq_el && !lock_held) begin
      lock_held <= 1'b1;
      lock_addr <= op_addr;
      lock_val <= op_wdata;
      lock_old <= op_lock_old;
    end
  end

  // Fallback address from the outermost begin
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fallback_pc <= '0;
    end else if (state == tle_pkg::TLE_IDLE && op_valid && op_begin) begin
      fallback_pc <= op_pc + op_offset;
    end
  end

  // Read and write sets, with buffered store data
  always_ff @(posedge core_clk) begin
    if (reset || do_abort || do_commit) begin
      rd_vld <= '0;
      wr_vld <= '0;
    end else begin
      if (rd_need && !rd_over) begin
        rd_vld[first_free(rd_vld)] <= 1'b1;
        rd_line[first_free(rd_vld)] <= line_of(op_addr);
      end
      if (wr_need && !wr_over) begin
        wr_vld[first_free(wr_vld)] <= 1'b1;
        wr_line[first_free(wr_vld)] <= line_of(op_addr);
        wr_data[first_free(wr_vld)] <= op_wdata;
        wr_addr[first_free(wr_vld)] <= op_addr;
      end else if (in_tx && is_store_op && !lock_line_op) begin
        for (int i = 0; i < tle_pkg::SET_DEPTH; i++) begin
          if (op_wr_hit[i]) begin
            wr_data[i] <= op_wdata;
            wr_addr[i] <= op_addr;
          end
        end
      end
    end
  end

  // Commit drain: buffered stores are released one set entry per cycle after commit
  always_ff @(posedge core_clk) begin
    if (reset) begin
      draining <= 1'b0;
      drain_vld <= '0;
      drain_idx <= '0;
    end else if (do_commit) begin
      draining <= 1'b1;
      drain_vld <= wr_vld;
      drain_idx <= '0;
    end else if (draining) begin
      drain_idx <= drain_idx + 1'b1;
      if (drain_idx == (tle_pkg::SET_IDX_W + 1)'(tle_pkg::SET_DEPTH - 1)) begin
        draining <= 1'b0;
      end
    end
  end

  // Memory writes: non-transactional stores pass only while not draining, drains follow commit
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mem_write_req <= 1'b0;
      mem_write_addr <= '0;
      mem_write_data <= '0;
    end else if (draining) begin
      mem_write_req <= drain_vld[drain_idx[tle_pkg::SET_IDX_W-1:0]];
      mem_write_addr <= wr_addr[drain_idx[tle_pkg::SET_IDX_W-1:0]];
      mem_write_data <= wr_data[drain_idx[tle_pkg::SET_IDX_W-1:0]];
    end else begin
      mem_write_req <= !in_tx && is_store_op;
      mem_write_addr <= op_addr;
      mem_write_data <= op_wdata;
    end
  end

  // Abort and commit outcomes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      commit_pulse <= 1'b0;
      abort_pulse <= 1'b0;
      restore_state <= 1'b0;
      redirect_valid <= 1'b0;
      redirect_pc <= '0;
      acc_write <= 1'b0;
      acc_value <= '0;
      rerun_no_elide <= 1'b0;
    end else begin
      commit_pulse <= do_commit;
      abort_pulse <= do_abort;
      restore_state <= do_abort;
      redirect_valid <= do_abort && state == tle_pkg::TLE_EXPLICIT;
      redirect_pc <= fallback_pc;
      rerun_no_elide <= do_abort && state == tle_pkg::TLE_PREFIX;
      acc_write <= do_abort && state == tle_pkg::TLE_EXPLICIT;
      acc_value <= '0;
      if (force_ab) begin
        acc_value[tle_pkg::ST_EXPLICIT] <= 1'b1;
        acc_value[tle_pkg::ST_CODE_LSB +: 8] <= op_imm;
      end else begin
        acc_value[tle_pkg::ST_RETRY] <= conflict;
      end
      acc_value[tle_pkg::ST_CONFLICT] <= conflict;
      acc_value[tle_pkg::ST_OVERFLOW] <= rd_over || wr_over;
      acc_value[tle_pkg::ST_NEST] <= nest_over;
    end
  end

  // Query result and lock forwarding
  always_ff @(posedge core_clk) begin
    if (reset) begin
      query_result <= 1'b0;
      lock_fwd_hit <= 1'b0;
      lock_fwd_data <= '0;
    end else begin
      query_result <= op_valid && op_query && in_tx && !do_abort;
      lock_fwd_hit <= in_tx && op_valid && op_is_load && lock_held
        && op_addr == lock_addr;
      lock_fwd_data <= lock_val;
    end
  end

  assign tx_active = in_tx;
endmodule : tle_core

// [tb/tle_asserts.sv]
// Port checker for tle_core.
// Bound to every tle_core; single core clock domain.
`timescale 1ns/100ps
module tle_asserts (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic elision_enable,
  input wire logic op_valid,
  input wire logic [7:0] op_prefix,
  input wire logic op_is_lock_acq,
  input wire logic op_is_lock_rel,
  input wire logic op_is_store,
  input wire logic op_begin,
  input wire logic op_force_abort,
  input wire logic op_query,
  input wire logic [7:0] op_imm,
  input wire logic [31:0] op_offset,
  input wire logic [31:0] op_pc,
  input wire logic [tle_pkg::ADDR_W-1:0] op_addr,
  input wire logic [tle_pkg::DATA_W-1:0] op_wdata,
  input wire logic sys_abort,
  input wire logic tx_active,
  input wire logic query_result,
  input wire logic mem_write_req,
  input wire logic [tle_pkg::ADDR_W-1:0] mem_write_addr,
  input wire logic [tle_pkg::DATA_W-1:0] mem_write_data,
  input wire logic abort_pulse,
  input wire logic restore_state,
  input wire logic redirect_valid,
  input wire logic [31:0] redirect_pc,
  input wire logic acc_write,
  input wire logic [tle_pkg::ACC_W-1:0] acc_value,
  input wire logic rerun_no_elide
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [31:0] fb_pc;
  logic rerun;
  // Fallback of the outermost begin
  always_ff @(posedge core_clk) begin
    if (reset) fb_pc <= 32'h0;
    else if (op_valid && op_begin && !tx_active) fb_pc <= op_pc + op_offset;
  end
  // Non-elided rerun lasts until a lock release
  always_ff @(posedge core_clk) begin
    if (reset || (op_valid && op_is_lock_rel)) rerun <= 1'b0;
    else if (rerun_no_elide) rerun <= 1'b1;
  end
  AST_BEGIN_ENTERS: assert property (op_valid && op_begin && !tx_active |=> tx_active)
    else $error("begin did not enter a transaction");
  AST_STORE_HIDDEN: assert property (tx_active && op_valid && op_is_store
    |=> !mem_write_req)
    else $error("transactional store became visible");
  AST_FORCE_STATUS: assert property (tx_active && op_valid && op_force_abort |=>
    abort_pulse && acc_write && acc_value[31:24] == $past(op_imm) && acc_value[1:0] == 2'b01)
    else $error("force abort status wrong");
  AST_ABORT_RESTORE: assert property (abort_pulse |-> restore_state && !tx_active)
    else $error("abort without restore");
  AST_QUERY: assert property (op_valid && op_query |=> query_result == $past(tx_active))
    else $error("query result wrong");
  AST_SYS_ABORT: assert property (tx_active && sys_abort |=> abort_pulse)
    else $error("system abort ignored");
  AST_ELIDE: assert property (elision_enable && !rerun && !rerun_no_elide
    && !tx_active && op_valid && op_is_lock_acq && op_prefix == tle_pkg::PREFIX_ACQ
    |=> tx_active && !mem_write_req)
    else $error("elided acquire wrote the lock");
  AST_NO_FEATURE: assert property (!elision_enable && op_valid && op_is_lock_acq
    && !tx_active |=> mem_write_req && mem_write_addr == $past(op_addr)
    && mem_write_data == $past(op_wdata))
    else $error("plain acquire not written");
  AST_FALLBACK_PC: assert property (redirect_valid |-> redirect_pc == fb_pc)
    else $error("redirect address wrong");
endmodule : tle_asserts

bind tle_core tle_asserts u_asserts (.*);

// [tb/tle_peer.sv]
// Peer logical processor: snoops the core, records what it sees written.
// Driven by bench tasks at falling edges of core_clk.
`timescale 1ns/100ps
module tle_peer (
  input wire logic core_clk,
  input wire logic mem_write_req,
  input wire logic [31:0] mem_write_addr,
  input wire logic [31:0] mem_write_data,
  output logic peer_valid,
  output logic peer_write,
  output logic [31:0] peer_addr
);
  logic [31:0] mem [logic [31:0]];
  initial begin
    peer_valid = 1'b0;
    peer_write = 1'b0;
    peer_addr = 32'h0;
  end
  // Peer view only holds committed or plain writes
  always @(negedge core_clk) begin
    if (mem_write_req === 1'b1) mem[mem_write_addr] = mem_write_data;
  end
  // One access, then junk on the idle bus
  task automatic snoop(input logic w, input logic [31:0] a);
    @(negedge core_clk);
    peer_valid = 1'b1;
    peer_write = w;
    peer_addr = a;
    @(negedge core_clk);
    peer_valid = 1'b0;
    peer_write = ~w;
    peer_addr = ~a;
  endtask : snoop
  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 32'h0;
  endfunction : peek
endmodule : tle_peer

// [tb/transactional_lock_elision_tb.sv]
// Self-checking bench for tle_core against a queue model and a peer.
// One 10 MHz core clock; inputs change at falling edges.
`timescale 1ns/100ps
module transactional_lock_elision_tb;
  logic core_clk = 1'b0, reset = 1'b1, elision_enable = 1'b0, op_valid = 1'b0, sys_abort = 1'b0;
  logic op_is_lock_acq = 1'b0, op_is_lock_rel = 1'b0, op_is_load = 1'b0, op_is_store = 1'b0;
  logic op_begin = 1'b0, op_end = 1'b0, op_force_abort = 1'b0, op_query = 1'b0;
  logic [7:0] op_prefix = 8'h0, op_imm = 8'h0, imm;
  logic [31:0] op_offset = 32'h0, op_pc = 32'h0, op_addr = 32'h0, op_wdata = 32'h0;
  logic [31:0] op_lock_old = 32'h0, mem_write_addr, mem_write_data, lock_fwd_data, redirect_pc;
  logic [31:0] acc_value, peer_addr;
  logic tx_active, query_result, mem_write_req, lock_fwd_hit, commit_pulse, abort_pulse;
  logic restore_state, redirect_valid, acc_write, rerun_no_elide, peer_valid, peer_write;
  logic [63:0] pend [$], expw [$];
  int nest = 0, fb = 0, seed, mismatches = 0, tests_run = 0;
  tle_core dut (.*);
  tle_peer peer (.*);
  always #50 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (e !== g) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // Kinds: load store begin end abort query acquire release
  task automatic op(input int k, input logic [31:0] a, input logic [31:0] d);
    if (k == 2 && nest == 0) fb = a + d;
    if (k == 2) nest++;
    if (k == 1 && nest > 0) pend.push_back({a, d});
    if (k == 3) nest--;
    if (k == 3 && nest == 0) expw = {expw, pend};
    if (k == 3 && nest == 0) pend.delete();
    @(negedge core_clk);
    op_valid = 1'b1;
    op_addr = a;
    op_pc = a;
    op_wdata = d;
    op_offset = d;
    op_imm = d[7:0];
    {op_is_load, op_is_store, op_begin, op_end, op_force_abort, op_query, op_is_lock_acq,
      op_is_lock_rel} = 8'h80 >> k;
    @(negedge core_clk);
    op_valid = 1'b0;
    {op_is_load, op_is_store, op_begin, op_end, op_force_abort, op_query, op_is_lock_acq,
      op_is_lock_rel} = 8'h0;
  endtask : op
  // Mode 0 prefix, 1 explicit with status, 2 explicit without
  task automatic aborted(input logic [3:0] st, input int mode);
    chk("abort", 1, abort_pulse);
    chk("restore", 1, restore_state);
    if (mode == 0) chk("rerun pulse", 1, rerun_no_elide);
    if (mode > 0) chk("redirect", {1'b1, fb[31:0]}, {redirect_valid, redirect_pc});
    if (mode == 1) chk("status", {1'b1, st}, {acc_write, acc_value[3:0]});
    pend.delete();
    nest = 0;
  endtask : aborted
  task automatic drain(input string n);
    int i;
    for (i = 0; i < 20 && expw.size() > 0; i++) @(negedge core_clk);
    // Stay clear of the commit drain window
    repeat (8) @(negedge core_clk);
    chk("drain", 0, expw.size());
    $display("test %s done", n);
    if (i == 20) tally_and_finish;
  endtask : drain
  always @(negedge core_clk) begin
    if (!reset && mem_write_req === 1'b1)
      chk("write", expw.size() ? expw.pop_front() : 64'h0,
        {mem_write_addr, mem_write_data});
  end
  initial begin
    seed = 72524;
    repeat (20) @(negedge core_clk);
    reset = 1'b0;
    op(2, 32'h100, 32'h40);
    op(2, 32'h200, 32'h10);
    op(1, 32'h1000, 32'($random(seed)));
    op(1, 32'h2040, 32'($random(seed)));
    chk("hidden", 0, peer.peek(32'h1000));
    op(5, 0, 0);
    chk("query", nest > 0, query_result);
    op(3, 0, 0);
    chk("inner end", 0, commit_pulse);
    op(3, 0, 0);
    chk("commit", 1, commit_pulse);
    drain("commit");
    op(2, 32'h300, 32'h20);
    op(2, 32'h400, 32'h8);
    op(0, 32'h3004, 0);
    peer.snoop(1'b1, 32'h3030);
    aborted(4'h6, 1);
    op(2, 32'h500, 32'h4);
    op(1, 32'h5000, 32'h5);
    peer.snoop(1'b0, 32'h503c);
    aborted(4'h6, 1);
    drain("conflict");
    op(2, 32'h600, 32'h4);
    op(1, 32'h6000, 32'h6);
    imm = 8'($random(seed));
    op(4, 0, {24'h0, imm});
    aborted(4'h1, 1);
    chk("immediate", imm, acc_value[31:24]);
    op(2, 32'h700, 32'h4);
    for (int i = 0; i < 9; i++) op(0, 32'(i) << 6, 0);
    aborted(4'h8, 1);
    op(2, 32'h800, 32'h4);
    @(negedge core_clk);
    sys_abort = 1'b1;
    @(negedge core_clk);
    sys_abort = 1'b0;
    aborted(4'h0, 2);
    drain("abort causes");
    elision_enable = 1'b1;
    op_prefix = tle_pkg::PREFIX_ACQ;
    op(6, 32'h9000, 32'h1);
    chk("elided", 1, tx_active);
    op_prefix = 8'h0;
    op(0, 32'h9000, 0);
    chk("forward", {1'b1, 32'h1}, {lock_fwd_hit, lock_fwd_data});
    peer.snoop(1'b0, 32'h9008);
    chk("peer read", 0, abort_pulse);
    chk("lock free", 0, peer.peek(32'h9000));
    op_prefix = tle_pkg::PREFIX_REL;
    op(7, 32'h9000, 0);
    chk("elide commit", 1, commit_pulse);
    drain("elision");
    op_prefix = tle_pkg::PREFIX_ACQ;
    op(6, 32'h9000, 32'h1);
    peer.snoop(1'b1, 32'h9000);
    aborted(4'h0, 0);
    expw.push_back({32'h9000, 32'h1});
    op(6, 32'h9000, 32'h1);
    chk("rerun", 0, tx_active);
    op(5, 0, 0);
    chk("query idle", 0, query_result);
    op_prefix = tle_pkg::PREFIX_REL;
    expw.push_back({32'h9000, 32'h0});
    op(7, 32'h9000, 0);
    drain("rerun");
    elision_enable = 1'b0;
    op_prefix = tle_pkg::PREFIX_ACQ;
    expw.push_back({32'h9000, 32'h1});
    op(6, 32'h9000, 32'h1);
    chk("no feature", 0, tx_active);
    op_prefix = tle_pkg::PREFIX_REL;
    expw.push_back({32'h9000, 32'h0});
    op(7, 32'h9000, 0);
    drain("no feature");
    tally_and_finish;
  end
endmodule : transactional_lock_elision_tb
